// ---- dv/flash_seq_error_lock_access_test.sv ----
// self-checking bench for the flash sequence, lock and access block
`timescale 1ns/1ns
module flash_seq_error_lock_access_test;
	import fsela_pkg::*;
	logic i_clock = 1'h0;
	logic i_resetn = 1'h0;
	logic i_flash_control_reg_wr = 1'h0;
	logic i_flash_status_reg_wr = 1'h0;
	logic i_latch_load = 1'h0;
	logic i_external_access_pin = 1'h1;
	logic go = 1'h0;
	logic [7:0] i_flash_control_reg_wdata = 8'h00;
	logic [7:0] i_flash_status_reg_wdata = 8'h00;
	logic [15:0] i_code_addr = 16'h0000;
	logic [2:0] bits = 3'h7;
	fsela_exec_t i_exec_space = EXEC_BOOT;
	logic i_par_mode_pin, i_par_lock_wr, o_prog_start, o_latch_reset;
	logic o_cpu_stall, o_external_access, o_ext_exec_ok, o_ext_code_space_read_instr_int_ok;
	logic o_par_flash_wr_ok, o_par_ee_wr_ok, o_par_verify_ok, o_par_ee_rd_ok;
	logic seen_start, seen_stall;
	logic [2:0] i_par_lock_data, o_lock_level;
	logic [7:0] o_flash_control_reg, o_flash_status_reg;
	logic [3:0] o_prog_op;
	logic [6:0] o_code_index;
	fsela_sel_t o_code_sel;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	fsela_core #(.MC_CLOCKS(4), .PROG_CYCLES(8)) dut (.i_clock, .i_resetn,
		.i_flash_control_reg_wr, .i_flash_control_reg_wdata, .i_flash_status_reg_wr, .i_flash_status_reg_wdata, .i_latch_load,
		.i_exec_space, .i_code_addr, .i_external_access_pin, .i_par_mode_pin,
		.i_par_lock_wr, .i_par_lock_data, .o_flash_control_reg,
		.o_flash_status_reg, .o_prog_start, .o_prog_op, .o_latch_reset,
		.o_cpu_stall, .o_code_sel, .o_code_index, .o_lock_level,
		.o_external_access, .o_ext_exec_ok, .o_ext_code_space_read_instr_int_ok,
		.o_par_flash_wr_ok, .o_par_ee_wr_ok, .o_par_verify_ok, .o_par_ee_rd_ok);
	fsela_par_model prog (.i_clock, .i_go(go), .i_bits(bits),
		.o_mode(i_par_mode_pin), .o_wr(i_par_lock_wr), .o_data(i_par_lock_data));
	always #10 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask : tick
	task automatic flash_control_reg(input logic [7:0] v);
		tick(1);
		i_flash_control_reg_wr = 1'h1;
		i_flash_control_reg_wdata = v;
		tick(1);
		i_flash_control_reg_wr = 1'h0;
	endtask : flash_control_reg
	task automatic wr2(input logic [7:0] a, input logic [7:0] b);
		tick(1);
		i_flash_control_reg_wr = 1'h1;
		i_flash_control_reg_wdata = a;
		tick(1);
		i_flash_control_reg_wdata = b;
		tick(1);
		i_flash_control_reg_wr = 1'h0;
	endtask : wr2
	task automatic flash_status_reg(input logic [7:0] v);
		tick(1);
		i_flash_status_reg_wr = 1'h1;
		i_flash_status_reg_wdata = v;
		tick(1);
		i_flash_status_reg_wr = 1'h0;
	endtask : flash_status_reg
	task automatic load();
		tick(1);
		i_latch_load = 1'h1;
		tick(1);
		i_latch_load = 1'h0;
	endtask : load
	task automatic launch(input logic [3:0] op);
		load();
		wr2({UNLOCK_HI, op}, {CONFIRM_HI, op});
		seen_start = 1'h0;
		seen_stall = 1'h0;
		tick(1);
		for (int i = 0; i < 100 && o_flash_status_reg[1] !== 1'h0; i++) begin
			seen_start |= o_prog_start;
			seen_stall |= o_cpu_stall;
			tick(1);
		end
	endtask : launch
	task automatic rd(input logic [15:0] a, input fsela_sel_t e);
		i_code_addr = a;
		tick(1);
		chk({o_code_sel, o_code_index}, {e, a[6:0]});
	endtask : rd
	task automatic lock();
		tick(1);
		go = 1'h1;
		tick(1);
		go = 1'h0;
		tick(8);
	endtask : lock
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(3);
		i_resetn = 1'h1;
		chk(o_lock_level, 3'h4);
		chk({o_ext_exec_ok, o_par_flash_wr_ok, o_flash_status_reg}, 10'h0);
		wr2(8'h50, 8'h00);
		chk(o_flash_status_reg[0], 1'h1);
		flash_status_reg(8'h01);
		chk(o_flash_status_reg[0], 1'h1);
		flash_status_reg(8'h00);
		chk(o_flash_status_reg[0], 1'h0);
		wr2(8'h50, 8'hA0);
		chk(o_flash_status_reg[1:0], 2'h1);
		$display("test status done");
		launch(OP_USER);
		chk({seen_start, seen_stall, o_prog_op}, 6'h20);
		chk(o_flash_status_reg, 8'h00);
		i_exec_space = EXEC_USER;
		launch(OP_EXTRA_ROW_SPACE);
		chk({seen_start, seen_stall, o_prog_op}, 6'h32);
		i_exec_space = EXEC_EXT;
		load();
		wr2(8'h50, 8'hA0);
		chk(o_flash_status_reg[1:0], 2'h1);
		i_exec_space = EXEC_USER;
		flash_status_reg(8'h00);
		wr2(8'h54, 8'hA4);
		chk({o_prog_op, o_flash_status_reg[1:0]}, 6'h11);
		i_exec_space = EXEC_BOOT;
		wr2(8'h56, 8'hA6);
		chk({o_latch_reset, o_flash_status_reg[2]}, 2'h2);
		$display("test program done");
		i_exec_space = EXEC_USER;
		flash_control_reg(MAP_EXTRA_ROW_SPACE);
		chk(o_flash_control_reg, MAP_EXTRA_ROW_SPACE);
		rd(16'hFF85, SEL_EXTRA_ROW_SPACE);
		rd(16'hFF7F, SEL_USER);
		flash_control_reg(MAP_SBYTE);
		rd(16'h0000, SEL_SBYTE);
		flash_control_reg(CTRL_RESET);
		rd(16'hFF85, SEL_USER);
		$display("test map done");
		for (int k = 0; k < 4; k++) begin
			bits = (k == 0) ? 3'h7 : ~(3'h1 << (k - 1));
			lock();
			chk(o_lock_level, 16'(k + 1));
			chk({o_ext_exec_ok, o_ext_code_space_read_instr_int_ok, o_par_flash_wr_ok,
				o_par_ee_wr_ok, o_par_verify_ok, o_par_ee_rd_ok},
				{k < 3, k == 0, k == 0, k == 0, k < 2, k < 2});
			i_exec_space = EXEC_EXT;
			rd(16'h0100, (k < 3) ? SEL_EXT : SEL_NONE);
			i_exec_space = EXEC_USER;
		end
		i_external_access_pin = 1'h0;
		tick(4);
		chk(o_external_access, 1'h1);
		bits = 3'h7;
		lock();
		chk(o_external_access, 1'h0);
		i_external_access_pin = 1'h1;
		tick(4);
		$display("test lock done");
		print_verdict();
	end
endmodule : flash_seq_error_lock_access_test

// ---- dv/fsela_core_properties.sv ----
// concurrent checks on the flash sequence, lock and access block
`timescale 1ns/1ns
module fsela_core_properties (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// requests
	input wire logic i_flash_control_reg_wr,
	input wire logic [7:0] i_flash_control_reg_wdata,
	input wire logic i_flash_status_reg_wr,
	input wire logic [7:0] i_flash_status_reg_wdata,
	input wire logic i_latch_load,
	input wire fsela_pkg::fsela_exec_t i_exec_space,
	input wire logic [15:0] i_code_addr,
	// observed outputs
	input wire logic [7:0] o_flash_control_reg,
	input wire logic [7:0] o_flash_status_reg,
	input wire logic o_latch_reset,
	input wire fsela_pkg::fsela_sel_t o_code_sel,
	input wire logic [2:0] o_lock_level,
	input wire logic o_external_access,
	input wire logic o_ext_exec_ok,
	input wire logic o_ext_code_space_read_instr_int_ok,
	input wire logic o_par_flash_wr_ok,
	input wire logic o_par_ee_wr_ok,
	input wire logic o_par_verify_ok,
	input wire logic o_par_ee_rd_ok
);
	import fsela_pkg::*;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	logic in_ok;
	assign in_ok = i_exec_space == EXEC_USER && o_external_access && !i_flash_control_reg_wr;
	////////////////////////////////////////////////////////////////////////
	AST_EXTRA_ROW_SPACE: assert property (
		in_ok && o_flash_control_reg == MAP_EXTRA_ROW_SPACE && i_code_addr >= EXTRA_ROW_SPACE_BASE
		|=> o_code_sel == SEL_EXTRA_ROW_SPACE) else $error("extra row not mapped");
	AST_SBYTE: assert property (
		in_ok && o_flash_control_reg == MAP_SBYTE && i_code_addr == SBYTE_ADDR
		|=> o_code_sel == SEL_SBYTE) else $error("security byte not mapped");
	AST_LVL2: assert property (o_lock_level >= 3'h2 |->
		!(o_ext_code_space_read_instr_int_ok || o_par_flash_wr_ok || o_par_ee_wr_ok))
		else $error("level two access left open");
	AST_LVL3: assert property (o_lock_level >= 3'h3 |->
		!(o_par_verify_ok || o_par_ee_rd_ok)) else $error("level three open");
	AST_LVL4: assert property (o_lock_level == 3'h4 |->
		!o_ext_exec_ok) else $error("external execution allowed");
	AST_SEQ: assert property (
		i_flash_control_reg_wr && i_flash_control_reg_wdata[7:4] == UNLOCK_HI ##1
		i_flash_control_reg_wr && i_flash_control_reg_wdata[7:4] != CONFIRM_HI
		|=> o_flash_status_reg[0]) else $error("broken pair not flagged");
	AST_EMPTY: assert property (
		i_flash_control_reg_wr && i_flash_control_reg_wdata == 8'h50 && !o_flash_status_reg[2] ##1
		i_flash_control_reg_wr && i_flash_control_reg_wdata == 8'hA0 && !o_flash_status_reg[2]
		|=> o_flash_status_reg[0]) else $error("empty launch not flagged");
	AST_CLR: assert property (
		i_flash_status_reg_wr && !i_flash_status_reg_wdata[0] && !i_flash_control_reg_wr && !o_flash_status_reg[1]
		|=> !o_flash_status_reg[0]) else $error("error not cleared");
	AST_DONE: assert property (
		$fell(o_flash_status_reg[1]) |-> o_flash_status_reg[2:0] == 3'h0)
		else $error("completion left flags set");
	AST_LRST: assert property (o_latch_reset |->
		o_flash_status_reg[2] == $past(i_latch_load)
		&& $past(i_flash_control_reg_wdata) == 8'hA6)
		else $error("latch reset mismatch");
endmodule : fsela_core_properties

bind fsela_core fsela_core_properties chk (.i_clock, .i_resetn, .i_flash_control_reg_wr,
	.i_flash_control_reg_wdata, .i_flash_status_reg_wr, .i_flash_status_reg_wdata, .i_latch_load, .i_exec_space,
	.i_code_addr, .o_flash_control_reg, .o_flash_status_reg, .o_latch_reset,
	.o_code_sel, .o_lock_level, .o_external_access, .o_ext_exec_ok,
	.o_ext_code_space_read_instr_int_ok, .o_par_flash_wr_ok, .o_par_ee_wr_ok, .o_par_verify_ok,
	.o_par_ee_rd_ok);

// ---- dv/fsela_par_model.sv ----
// parallel programmer model that writes the lock bits on request
`timescale 1ns/1ns
module fsela_par_model (
	// clock and request
	input wire logic i_clock,
	input wire logic i_go,
	input wire logic [2:0] i_bits,
	// programmer pins
	output logic o_mode,
	output logic o_wr,
	output logic [2:0] o_data
);
	////////////////////////////////////////////////////////////////////////
	initial begin
		o_mode = 1'h0;
		o_wr = 1'h0;
		o_data = 3'h0;
		forever begin
			@(posedge i_clock iff i_go);
			#2;
			o_mode = 1'h1;
			repeat (3) @(posedge i_clock);
			#2;
			o_wr = 1'h1;
			o_data = i_bits;
			@(posedge i_clock);
			#2;
			o_wr = 1'h0;
			// released bus shows no stale value
			o_data = ~i_bits;
			o_mode = 1'h0;
		end
	end
endmodule : fsela_par_model

// ---- logic/fsela_core.sv ----
// flash sequence checker, read mapping and lock access control
`timescale 1ns/1ns
module fsela_core #(
	parameter int MC_CLOCKS = fsela_pkg::MC_CLOCKS_DEF,
	parameter int PROG_CYCLES = fsela_pkg::PROG_CYCLES_DEF
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// cpu writes to control and status
	input wire logic i_flash_control_reg_wr,
	input wire logic [7:0] i_flash_control_reg_wdata,
	input wire logic i_flash_status_reg_wr,
	input wire logic [7:0] i_flash_status_reg_wdata,
	// column latch load strobe
	input wire logic i_latch_load,
	// executing code space
	input wire fsela_pkg::fsela_exec_t i_exec_space,
	// code-space read address
	input wire logic [15:0] i_code_addr,
	// pins
	input wire logic i_external_access_pin,
	input wire logic i_par_mode_pin,
	// parallel programmer lock write
	input wire logic i_par_lock_wr,
	input wire logic [2:0] i_par_lock_data,
	// register views
	output logic [7:0] o_flash_control_reg,
	output logic [7:0] o_flash_status_reg,
	// flash macro control
	output logic o_prog_start,
	output logic [3:0] o_prog_op,
	output logic o_latch_reset,
	output logic o_cpu_stall,
	// code read mapping
	output fsela_pkg::fsela_sel_t o_code_sel,
	output logic [6:0] o_code_index,
	// protection
	output logic [2:0] o_lock_level,
	output logic o_external_access,
	output logic o_ext_exec_ok,
	output logic o_ext_code_space_read_instr_int_ok,
	output logic o_par_flash_wr_ok,
	output logic o_par_ee_wr_ok,
	output logic o_par_verify_ok,
	output logic o_par_ee_rd_ok
);
	import fsela_pkg::*;

	localparam int MCW = $clog2(MC_CLOCKS);
	localparam int PCW = $clog2(PROG_CYCLES + 1);
	localparam logic [MCW-1:0] MC_LAST = MCW'(MC_CLOCKS - 1);
	localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);

	generate
		if (MC_CLOCKS < 2) begin : g_bad_mc
			$error("MC_CLOCKS must be at least 2");
		end
		if (PROG_CYCLES < 1) begin : g_bad_prog
			$error("PROG_CYCLES must be at least 1");
		end
	endgenerate

	typedef struct packed {
		fsela_state_t state;
		logic [7:0] ctrl;
		logic armed;
		logic [3:0] op;
		logic rww;
		logic sequence_error_flag;
		logic loaded;
		logic [2:0] lock;
		logic ea_s1;
		logic ea_s2;
		logic pm_s1;
		logic pm_s2;
		logic [1:0] ea_wait;
		logic ea_cap;
		logic [MCW-1:0] mc_cnt;
		logic [1:0] mc_left;
		logic [PCW-1:0] prog_cnt;
		logic start_p;
		logic lreset_p;
		fsela_sel_t sel;
		logic [6:0] idx;
	} fsela_regs_t;

	localparam fsela_regs_t REGS_RESET = '{
		state: ST_IDLE,
		ctrl: CTRL_RESET,
		armed: 1'b0,
		op: OP_USER,
		rww: 1'b0,
		sequence_error_flag: 1'b0,
		loaded: 1'b0,
		lock: LOCK_RESET,
		ea_s1: 1'b0,
		ea_s2: 1'b0,
		pm_s1: 1'b0,
		pm_s2: 1'b0,
		ea_wait: 2'h0,
		ea_cap: 1'b0,
		mc_cnt: '0,
		mc_left: 2'h0,
		prog_cnt: '0,
		start_p: 1'b0,
		lreset_p: 1'b0,
		sel: SEL_USER,
		idx: 7'h00
	};

	fsela_regs_t r_reg;
	fsela_regs_t r_next;

	logic [2:0] level;
	logic ext_exec_ok;
	logic ext_code_space_read_instr_int_ok;
	logic mc_tick;
	logic busy;
	logic ea_eff;
	logic launch_ok;
	logic [3:0] w_hi;
	logic [3:0] w_lo;

	////////////////////////////////////////////////////////////////////////
	// lock level decode

	fsela_lock_decode u_lock (
		.i_lock_bits(r_reg.lock),
		.o_level(level),
		.o_ext_code_space_read_instr_int_ok(ext_code_space_read_instr_int_ok),
		.o_par_flash_wr_ok(o_par_flash_wr_ok),
		.o_par_ee_wr_ok(o_par_ee_wr_ok),
		.o_par_verify_ok(o_par_verify_ok),
		.o_par_ee_rd_ok(o_par_ee_rd_ok),
		.o_ext_exec_ok(ext_exec_ok)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// one-cycle enable at the end of each machine cycle
	assign mc_tick = (r_reg.mc_cnt == MC_LAST);
	assign busy = (r_reg.state != ST_IDLE);
	assign w_hi = i_flash_control_reg_wdata[7:4];
	assign w_lo = i_flash_control_reg_wdata[3:0];
	// from level two the pin level caught after reset is used
	assign ea_eff = (level >= 3'h2) ? r_reg.ea_cap : r_reg.ea_s2;

	// write rights per executing space
	always_comb begin
		case (i_exec_space)
			EXEC_BOOT: begin
				launch_ok = 1'b1;
			end
			EXEC_USER: begin
				launch_ok = (r_reg.op == OP_USER) || (r_reg.op == OP_EXTRA_ROW_SPACE)
					|| (r_reg.op == OP_LRESET);
			end
			default: begin
				launch_ok = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		r_next = r_reg;
		r_next.start_p = 1'b0;
		r_next.lreset_p = 1'b0;

		// machine cycle divider
		r_next.mc_cnt = mc_tick ? '0 : r_reg.mc_cnt + 1'b1;

		// pin synchronisers
		r_next.ea_s1 = i_external_access_pin;
		r_next.ea_s2 = r_reg.ea_s1;
		r_next.pm_s1 = i_par_mode_pin;
		r_next.pm_s2 = r_reg.pm_s1;

		// catch the access pin once it has settled after reset
		if (r_reg.ea_wait != EA_SETTLE) begin
			r_next.ea_wait = r_reg.ea_wait + 2'h1;
			r_next.ea_cap = r_reg.ea_s2;
		end

		// lock bits change only in parallel programming mode
		if (r_reg.pm_s2 && i_par_lock_wr) begin
			r_next.lock = i_par_lock_data;
		end

		// software clear, zero in the bit position clears
		if (i_flash_status_reg_wr && !i_flash_status_reg_wdata[STA_SEQUENCE_ERROR_FLAG_BIT]) begin
			r_next.sequence_error_flag = 1'b0;
		end

		// latches keep their content while a write is pending or running
		if (i_latch_load && !busy) begin
			r_next.loaded = 1'b1;
		end

		case (r_reg.state)
			ST_IDLE: begin
			end
			ST_WAIT: begin
				if (mc_tick) begin
					r_next.mc_left = r_reg.mc_left - 2'h1;
					if (r_reg.mc_left == 2'h1) begin
						r_next.state = ST_PROG;
						r_next.start_p = 1'b1;
						r_next.prog_cnt = PROG_LAST;
					end
				end
			end
			ST_PROG: begin
				if (r_reg.prog_cnt == '0) begin
					r_next.state = ST_IDLE;
					r_next.rww = 1'b0;
					r_next.sequence_error_flag = 1'b0;
					r_next.loaded = 1'b0;
				end else begin
					r_next.prog_cnt = r_reg.prog_cnt - 1'b1;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase

		// control writes; errors are applied last so a set beats a clear
		if (i_flash_control_reg_wr) begin
			r_next.ctrl = i_flash_control_reg_wdata;
			r_next.armed = 1'b0;
			if (r_reg.armed) begin
				if (w_hi != CONFIRM_HI || w_lo != r_reg.op || busy
					|| !launch_ok) begin
					r_next.sequence_error_flag = 1'b1;
				end else if (r_reg.op == OP_LRESET) begin
					// a byte loaded in this same cycle survives the reset
					r_next.loaded = i_latch_load;
					r_next.lreset_p = 1'b1;
				end else if (!r_reg.loaded) begin
					r_next.sequence_error_flag = 1'b1;
				end else begin
					r_next.state = ST_WAIT;
					r_next.mc_left = LAUNCH_MCS;
					r_next.rww = (i_exec_space == EXEC_BOOT);
				end
			end
			if (w_hi == UNLOCK_HI) begin
				r_next.armed = 1'b1;
				r_next.op = w_lo;
			end
		end

		// code-space read mapping
		r_next.idx = i_code_addr[6:0];
		if (i_exec_space == EXEC_EXT || !ea_eff) begin
			r_next.sel = ext_exec_ok ? SEL_EXT : SEL_NONE;
		end else if (r_reg.ctrl == MAP_EXTRA_ROW_SPACE && i_code_addr >= EXTRA_ROW_SPACE_BASE) begin
			r_next.sel = SEL_EXTRA_ROW_SPACE;
		end else if (r_reg.ctrl == MAP_SBYTE && i_code_addr == SBYTE_ADDR) begin
			r_next.sel = SEL_SBYTE;
		end else begin
			r_next.sel = SEL_USER;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			r_reg <= REGS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_flash_control_reg = r_reg.ctrl;
	always_comb begin
		o_flash_status_reg = 8'h00;
		o_flash_status_reg[STA_SEQUENCE_ERROR_FLAG_BIT] = r_reg.sequence_error_flag;
		o_flash_status_reg[STA_BUSY_BIT] = busy;
		o_flash_status_reg[STA_LOAD_BIT] = r_reg.loaded;
	end
	assign o_prog_start = r_reg.start_p;
	assign o_prog_op = r_reg.op;
	assign o_latch_reset = r_reg.lreset_p;
	// the cpu is held only for writes that are not read-while-write
	assign o_cpu_stall = (r_reg.state == ST_PROG) && !r_reg.rww;
	assign o_code_sel = r_reg.sel;
	assign o_code_index = r_reg.idx;
	assign o_lock_level = level;
	assign o_external_access = ea_eff;
	assign o_ext_exec_ok = ext_exec_ok;
	assign o_ext_code_space_read_instr_int_ok = ext_code_space_read_instr_int_ok;

endmodule : fsela_core

// ---- logic/fsela_lock_decode.sv ----
// lock bits to protection level and access permissions
`timescale 1ns/1ns
module fsela_lock_decode (
	// lock bits, 0 = programmed
	input wire logic [2:0] i_lock_bits,
	// decoded level and permissions
	output logic [2:0] o_level,
	output logic o_ext_code_space_read_instr_int_ok,
	output logic o_par_flash_wr_ok,
	output logic o_par_ee_wr_ok,
	output logic o_par_verify_ok,
	output logic o_par_ee_rd_ok,
	output logic o_ext_exec_ok
);
	import fsela_pkg::*;

	always_comb begin
		if (!i_lock_bits[2]) begin
			o_level = 3'h4;
		end else if (!i_lock_bits[1]) begin
			o_level = 3'h3;
		end else if (!i_lock_bits[0]) begin
			o_level = 3'h2;
		end else begin
			o_level = 3'h1;
		end
	end

	assign o_ext_code_space_read_instr_int_ok = (o_level < 3'h2);
	assign o_par_flash_wr_ok = (o_level < 3'h2);
	assign o_par_ee_wr_ok = (o_level < 3'h2);
	assign o_par_verify_ok = (o_level < 3'h3);
	assign o_par_ee_rd_ok = (o_level < 3'h3);
	assign o_ext_exec_ok = (o_level < 3'h4);

endmodule : fsela_lock_decode

// ---- logic/fsela_pkg.sv ----
// constants and types for the flash sequence, lock and access block
// Functional notes
// - 5x write not followed by Ax sets error
// - launch with empty column latches sets error
// - error cleared by software or good completion
// - control 02h maps extra row at FF80h-FFFFh
// - control 04h maps security byte at 0000h
// - cleared control returns user flash reads
// - three lock bits grade levels one to four
// - lock bits parallel-writable only, default level four
// - level two: no internal fetch, latched pin
// - level two: parallel eeprom writes blocked
// - level three: parallel verify and eeprom blocked
// - level four: external execution refused
// - write rights depend on executing code space
// - read-while-write keeps cpu fetching during writes
// - start on second machine cycle, clear busy
// - 56h then A6h resets column latches
package fsela_pkg;

	// control register codes
	localparam logic [3:0] UNLOCK_HI = 4'h5;
	localparam logic [3:0] CONFIRM_HI = 4'hA;
	localparam logic [3:0] OP_USER = 4'h0;
	localparam logic [3:0] OP_EXTRA_ROW_SPACE = 4'h2;
	localparam logic [3:0] OP_SBYTE = 4'h4;
	localparam logic [3:0] OP_LRESET = 4'h6;
	localparam logic [7:0] MAP_EXTRA_ROW_SPACE = 8'h02;
	localparam logic [7:0] MAP_SBYTE = 8'h04;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// code-space addresses
	localparam logic [15:0] EXTRA_ROW_SPACE_BASE = 16'hFF80;
	localparam logic [15:0] SBYTE_ADDR = 16'h0000;

	// status register bit positions
	localparam int STA_SEQUENCE_ERROR_FLAG_BIT = 0;
	localparam int STA_BUSY_BIT = 1;
	localparam int STA_LOAD_BIT = 2;

	// lock bits: 1 unprogrammed, 0 programmed; default bit two programmed
	localparam logic [2:0] LOCK_RESET = 3'h3;

	// timing
	localparam int MC_CLOCKS_DEF = 12;
	localparam int PROG_CYCLES_DEF = 2000;
	localparam logic [1:0] LAUNCH_MCS = 2'h2;
	localparam logic [1:0] EA_SETTLE = 2'h3;

	// where the cpu is executing
	typedef enum logic [1:0] {
		EXEC_USER = 2'h0,
		EXEC_BOOT = 2'h1,
		EXEC_EXT = 2'h2
	} fsela_exec_t;

	// source of a code-space read
	typedef enum logic [2:0] {
		SEL_USER = 3'h0,
		SEL_EXTRA_ROW_SPACE = 3'h1,
		SEL_SBYTE = 3'h2,
		SEL_EXT = 3'h3,
		SEL_NONE = 3'h4
	} fsela_sel_t;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_PROG = 3'h4
	} fsela_state_t;

endpackage : fsela_pkg
